// *** logic/pecc_regs.svh ***
`ifndef PECC_REGS_SVH
`define PECC_REGS_SVH
// Functional notes
// - Count once per rise of die temperature above the trip threshold, event 3BH.
// - After a trip, lower frequency and voltage without any software request.
// - While throttled, sample temperature each millisecond; restore when below threshold.
// - Event 3CH mask 00H counts core clock cycles while core is not halted.
// - Core counts as halted from halt instruction onward; no running counts then.
// - Running core-cycle count follows the actual core clock, whatever its rate.
// - Event 3CH mask 01H counts bus cycles while core is not halted.
// - Running bus-cycle count keeps fixed ratio to the reference running cycle count.
// - Event 3CH mask 02H counts bus cycles when this core runs, other halted.
// - Event 40H counts cacheable reads matching line state, excluding locked reads.
// - Event 41H counts cacheable writes matching line state, excluding locked writes.
// - Event 42H counts only locked cacheable reads matching line state.
// ==========================================================
// Event codes and masks
`define PECC_EV_TRIP 8'h3b
`define PECC_UM_TRIP 8'hc0
`define PECC_EV_RUN 8'h3c
`define PECC_UM_CORE 8'h00
`define PECC_UM_BUS 8'h01
`define PECC_UM_SOLE 8'h02
`define PECC_EV_RD 8'h40
`define PECC_EV_WR 8'h41
`define PECC_EV_LK 8'h42
// ==========================================================
// Timing
`define PECC_CLK_HZ 100000000
`define PECC_SAMPLE_US 1000
`define PECC_SAMPLE_CYC ((`PECC_CLK_HZ / 1000000) * `PECC_SAMPLE_US)
`define PECC_CNT_RST 48'h0
`endif

// *** logic/pecc_pkg.sv ***
package pecc_pkg;
    typedef enum logic [1:0] {
        PECC_NORMAL,
        PECC_THROTTLED,
        PECC_SAMPLE
    } pecc_thr_e;
    typedef logic [7:0] pecc_code_t;
endpackage

// *** logic/pecc_sync.sv ***
`timescale 1ns/1ps
module pecc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_dout;

    always_comb begin
        next_meta = srst ? '0 : din;
        next_dout = srst ? '0 : meta;
    end

    always_ff @(posedge ref_clk) begin
        meta <= next_meta;
        dout <= next_dout;
    end
endmodule

// *** logic/pecc_core.sv ***
`timescale 1ns/1ps
`include "pecc_regs.svh"
module pecc_core import pecc_pkg::*; #(
    parameter int CNT_W = 48,
    parameter int SAMPLE_CYC = `PECC_SAMPLE_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] event_code,
    input wire logic [7:0] unit_mask,
    input wire logic core_tick,
    input wire logic bus_tick,
    input wire logic halt_instruction,
    input wire logic wake,
    input wire logic other_core_halted,
    input wire logic over_trip,
    input wire logic cache_rd,
    input wire logic cache_wr,
    input wire logic cache_locked,
    input wire logic [3:0] line_state,
    output logic [CNT_W-1:0] event_count,
    output logic throttle,
    output logic core_halted
);
    // ==========================================================
    // Input synchronisation
    // Sensor and sibling status come from other domains; ticks are local.
    logic [1:0] sync_in;
    logic trip_s;
    logic other_halted_s;

    pecc_sync #(
        .WIDTH(2)
    ) u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .din({over_trip, other_core_halted}),
        .dout(sync_in)
    );

    assign trip_s = sync_in[1];
    assign other_halted_s = sync_in[0];

    // ==========================================================
    // Event selection
    function automatic logic sel_match(input pecc_code_t ev, input pecc_code_t um,
                                       input pecc_code_t want_ev, input pecc_code_t want_um);
        sel_match = (ev == want_ev) && (um == want_um);
    endfunction

    function automatic logic state_ok(input logic [3:0] mask, input logic [3:0] st);
        state_ok = |(mask & st);
    endfunction

    // ==========================================================
    // Halt tracking and thermal throttle
    logic trip_d;
    logic next_trip_d;
    logic next_core_halted;
    pecc_thr_e thr_state;
    pecc_thr_e next_thr_state;
    logic next_throttle;
    logic [31:0] ms_cnt;
    logic [31:0] next_ms_cnt;
    logic trip_rise;

    assign trip_rise = trip_s && !trip_d;

    always_comb begin
        next_trip_d = trip_s;
        next_core_halted = core_halted;
        if (halt_instruction) begin
            next_core_halted = 1'b1;
        end else if (wake) begin
            next_core_halted = 1'b0;
        end
        next_thr_state = thr_state;
        next_ms_cnt = ms_cnt;
        unique case (thr_state)
            PECC_NORMAL: begin
                if (trip_rise) begin
                    next_thr_state = PECC_THROTTLED;
                    next_ms_cnt = 32'(SAMPLE_CYC - 1);
                end
            end
            PECC_THROTTLED: begin
                if (ms_cnt == 32'h0) begin
                    next_thr_state = PECC_SAMPLE;
                end else begin
                    next_ms_cnt = ms_cnt - 32'h1;
                end
            end
            PECC_SAMPLE: begin
                if (trip_s) begin
                    next_thr_state = PECC_THROTTLED;
                    next_ms_cnt = 32'(SAMPLE_CYC - 2);
                end else begin
                    next_thr_state = PECC_NORMAL;
                end
            end
            // The fourth code is unused; fall back to normal running rather than lock up
            default: begin
                next_thr_state = PECC_NORMAL;
            end
        endcase
        next_throttle = (next_thr_state != PECC_NORMAL);
        if (srst) begin
            next_trip_d = 1'b0;
            next_core_halted = 1'b0;
            next_thr_state = PECC_NORMAL;
            next_ms_cnt = 32'h0;
            next_throttle = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        trip_d <= next_trip_d;
        core_halted <= next_core_halted;
        thr_state <= next_thr_state;
        ms_cnt <= next_ms_cnt;
        throttle <= next_throttle;
    end

    // ==========================================================
    // Counter
    // A single increment per cycle: only one source can be selected at once.
    logic inc;
    logic [CNT_W-1:0] next_event_count;
    logic running;

    // The halt cycle itself is blocked, so no count slips in before core_halted rises
    assign running = !core_halted && !halt_instruction;

    always_comb begin
        inc = 1'b0;
        if (sel_match(event_code, unit_mask, `PECC_EV_TRIP, `PECC_UM_TRIP)) begin
            inc = trip_rise;
        end else if (sel_match(event_code, unit_mask, `PECC_EV_RUN, `PECC_UM_CORE)) begin
            inc = core_tick && running;
        end else if (sel_match(event_code, unit_mask, `PECC_EV_RUN, `PECC_UM_BUS)) begin
            inc = bus_tick && running;
        end else if (sel_match(event_code, unit_mask, `PECC_EV_RUN, `PECC_UM_SOLE)) begin
            inc = bus_tick && running && other_halted_s;
        end else if (event_code == `PECC_EV_RD) begin
            inc = cache_rd && !cache_locked && state_ok(unit_mask[3:0], line_state);
        end else if (event_code == `PECC_EV_WR) begin
            inc = cache_wr && !cache_locked && state_ok(unit_mask[3:0], line_state);
        end else if (event_code == `PECC_EV_LK) begin
            inc = cache_rd && cache_locked && state_ok(unit_mask[3:0], line_state);
        end
        next_event_count = event_count + CNT_W'(inc);
        if (srst) begin
            next_event_count = CNT_W'(`PECC_CNT_RST);
        end
    end

    always_ff @(posedge ref_clk) begin
        event_count <= next_event_count;
    end

    // ==========================================================
    // Assertions
    a_trip_count: assert property (@(posedge ref_clk) disable iff (srst)
        (sel_match(event_code, unit_mask, `PECC_EV_TRIP, `PECC_UM_TRIP) && trip_rise)
        |=> event_count == $past(event_count) + CNT_W'(1))
        else $error("trip not counted");
    a_trip_throttle: assert property (@(posedge ref_clk) disable iff (srst)
        (thr_state == PECC_NORMAL && trip_rise) |=> throttle)
        else $error("no throttle after trip");
    a_throttle_hold: assert property (@(posedge ref_clk) disable iff (srst)
        (thr_state == PECC_SAMPLE && trip_s) |=> throttle && thr_state == PECC_THROTTLED)
        else $error("throttle released while hot");
    a_restore_cool: assert property (@(posedge ref_clk) disable iff (srst)
        (thr_state == PECC_SAMPLE && !trip_s) |=> !throttle)
        else $error("no restore when cool");
    a_core_cycles: assert property (@(posedge ref_clk) disable iff (srst)
        (sel_match(event_code, unit_mask, `PECC_EV_RUN, `PECC_UM_CORE) && core_tick && running)
        |=> event_count != $past(event_count))
        else $error("core cycle missed");
    a_halt_quiet: assert property (@(posedge ref_clk) disable iff (srst)
        (core_halted && event_code == `PECC_EV_RUN) |=> $stable(event_count))
        else $error("count while halted");
    a_halt_sticks: assert property (@(posedge ref_clk) disable iff (srst)
        halt_instruction |=> core_halted)
        else $error("halt not entered");
    a_sole_bus: assert property (@(posedge ref_clk) disable iff (srst)
        (sel_match(event_code, unit_mask, `PECC_EV_RUN, `PECC_UM_SOLE) && !other_halted_s)
        |=> $stable(event_count))
        else $error("sole count with sibling running");
    a_locked_excluded: assert property (@(posedge ref_clk) disable iff (srst)
        (event_code == `PECC_EV_RD && cache_locked) |=> $stable(event_count))
        else $error("locked read counted");
    a_step_one: assert property (@(posedge ref_clk) disable iff (srst)
        (event_count - $past(event_count)) <= CNT_W'(1))
        else $error("step above one");
    a_bus_cycles: assert property (@(posedge ref_clk) disable iff (srst)
        (sel_match(event_code, unit_mask, `PECC_EV_RUN, `PECC_UM_BUS) && bus_tick && running)
        |=> event_count == $past(event_count) + CNT_W'(1))
        else $error("bus cycle missed");
    a_sole_count: assert property (@(posedge ref_clk) disable iff (srst)
        (sel_match(event_code, unit_mask, `PECC_EV_RUN, `PECC_UM_SOLE) && bus_tick && running
        && other_halted_s) |=> event_count == $past(event_count) + CNT_W'(1))
        else $error("sole bus cycle missed");
    a_read_counted: assert property (@(posedge ref_clk) disable iff (srst)
        (event_code == `PECC_EV_RD && cache_rd && !cache_locked
        && state_ok(unit_mask[3:0], line_state)) |=> event_count == $past(event_count) + CNT_W'(1))
        else $error("cacheable read missed");
    a_write_locked: assert property (@(posedge ref_clk) disable iff (srst)
        (event_code == `PECC_EV_WR && cache_locked) |=> $stable(event_count))
        else $error("locked write counted");
    a_lock_only: assert property (@(posedge ref_clk) disable iff (srst)
        (event_code == `PECC_EV_LK && !cache_locked) |=> $stable(event_count))
        else $error("unlocked read counted as locked");
    a_sample_due: assert property (@(posedge ref_clk) disable iff (srst)
        (thr_state == PECC_THROTTLED && ms_cnt == 32'h0) |=> thr_state == PECC_SAMPLE)
        else $error("temperature sample skipped");

    c_trip: cover property (@(posedge ref_clk) disable iff (srst) throttle ##1 !throttle);
    c_halt: cover property (@(posedge ref_clk) disable iff (srst) core_halted ##1 !core_halted);
    c_lock: cover property (@(posedge ref_clk) disable iff (srst)
        event_code == `PECC_EV_LK && cache_rd && cache_locked);
    c_sole: cover property (@(posedge ref_clk) disable iff (srst)
        sel_match(event_code, unit_mask, `PECC_EV_RUN, `PECC_UM_SOLE) && bus_tick && running
        && other_halted_s);
endmodule

// *** bench/pecc_far.sv ***
`timescale 1ns/1ps
module pecc_far (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic throttle,
    input wire logic hot,
    output logic core_tick,
    output logic bus_tick,
    output logic over_trip
);
    // ==========================================
    // Clock sources
    // Processor clock halves while throttled, so running core-cycle counts drift from wall time
    logic [1:0] ph;
    always_ff @(negedge ref_clk) begin
        ph <= srst ? 2'h0 : ph + 2'h1;
    end
    assign core_tick = throttle ? ph[0] : 1'b1;
    assign bus_tick = (ph == 2'h3);
    assign over_trip = hot;
endmodule

// *** bench/perf_event_core_cycle_cache_counter_bench.sv ***
`timescale 1ns/1ps
module perf_event_core_cycle_cache_counter_bench;
    import pecc_pkg::*;
    // ==========================================
    // Stimulus
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] event_code = 8'h3c;
    logic [7:0] unit_mask = 8'h00;
    logic halt_instruction = 1'b0;
    logic wake = 1'b0;
    logic other_core_halted = 1'b0;
    logic cache_rd = 1'b0;
    logic cache_wr = 1'b0;
    logic cache_locked = 1'b0;
    logic [3:0] line_state = 4'h1;
    logic hot = 1'b0;
    logic core_tick, bus_tick, over_trip, throttle, core_halted;
    logic [47:0] event_count;
    logic [47:0] base;
    int error_cnt = 0;
    int n_tests = 0;
    always #5 ref_clk = ~ref_clk;
    pecc_far far (.ref_clk(ref_clk), .srst(srst), .throttle(throttle), .hot(hot),
        .core_tick(core_tick), .bus_tick(bus_tick), .over_trip(over_trip));
    pecc_core #(.SAMPLE_CYC(8)) DUT (.ref_clk(ref_clk), .srst(srst),
        .event_code(event_code), .unit_mask(unit_mask), .core_tick(core_tick),
        .bus_tick(bus_tick), .halt_instruction(halt_instruction), .wake(wake),
        .other_core_halted(other_core_halted), .over_trip(over_trip),
        .cache_rd(cache_rd), .cache_wr(cache_wr), .cache_locked(cache_locked),
        .line_state(line_state), .event_count(event_count), .throttle(throttle),
        .core_halted(core_halted));
    // ==========================================
    // Helpers
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic sel(input logic [7:0] c, input logic [7:0] m);
        event_code = c;
        unit_mask = m;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic span(input int n, input logic [47:0] exp, input string msg);
        base = event_count;
        repeat (n) @(negedge ref_clk);
        check(event_count - base === exp, msg);
    endtask
    task automatic pulse(input bit h);
        halt_instruction = h;
        wake = !h;
        @(negedge ref_clk);
        halt_instruction = 1'b0;
        wake = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic acc(input bit rd, wr, lk, input logic [3:0] ls, input logic [47:0] exp);
        base = event_count;
        cache_rd = rd;
        cache_wr = wr;
        cache_locked = lk;
        line_state = ls;
        @(negedge ref_clk);
        cache_rd = 1'b0;
        cache_wr = 1'b0;
        @(negedge ref_clk);
        check(event_count - base === exp, "cache count");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_run;
        sel(8'h3c, 8'h00);
        span(20, 20, "core cycles");
        pulse(1);
        span(20, 0, "halted core cycles");
        check(core_halted === 1'b1, "halt level");
        pulse(0);
        check(core_halted === 1'b0, "wake level");
        span(8, 8, "after wake");
        sel(8'h3c, 8'h01);
        span(20, 5, "bus cycles");
        sel(8'h3c, 8'h02);
        span(20, 0, "sole, other running");
        other_core_halted = 1'b1;
        repeat (4) @(negedge ref_clk);
        span(20, 5, "sole, other halted");
        pulse(1);
        span(20, 0, "sole, both halted");
        pulse(0);
        other_core_halted = 1'b0;
        sel(8'h3c, 8'h03);
        span(20, 0, "unknown mask");
        $display("done run cycles");
    endtask
    task automatic t_cache;
        sel(8'h40, 8'h0f);
        acc(1, 0, 0, 4'h1, 1);
        acc(1, 0, 1, 4'h1, 0);
        acc(0, 1, 0, 4'h2, 0);
        sel(8'h41, 8'h0f);
        acc(0, 1, 0, 4'h4, 1);
        acc(0, 1, 1, 4'h4, 0);
        sel(8'h42, 8'h0f);
        acc(1, 0, 1, 4'h8, 1);
        acc(1, 0, 0, 4'h8, 0);
        sel(8'h40, 8'h01);
        acc(1, 0, 0, 4'h2, 0);
        $display("done cache");
    endtask
    task automatic t_trip;
        sel(8'h3b, 8'hc0);
        hot = 1'b1;
        span(6, 1, "trip count");
        check(throttle === 1'b1, "throttle on");
        span(20, 0, "no recount while hot");
        sel(8'h3c, 8'h00);
        span(20, 10, "slow core cycles");
        hot = 1'b0;
        repeat (20) if (throttle !== 1'b0) @(negedge ref_clk);
        check(throttle === 1'b0, "throttle off");
        @(negedge ref_clk);
        span(20, 20, "full core cycles");
        $display("done trip");
    endtask
    initial begin
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        @(negedge ref_clk);
        t_run();
        t_cache();
        t_trip();
        tally_and_finish();
    end
    initial begin
        #50000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
